//--- rtl/iocr_consts.svh
// Constants for the ISA I/O command and channel-ready logic
`ifndef IOCR_CONSTS_SVH
`define IOCR_CONSTS_SVH

// -----------------------------------------------------------------
// Clock and timing
// -----------------------------------------------------------------
`define IOCR_CLK_MHZ 100
`define IOCR_ISA_DIV 4
`define IOCR_RDY_RELEASE_NS 70
`define IOCR_RDY_RELEASE_CYC ((`IOCR_RDY_RELEASE_NS * `IOCR_CLK_MHZ) / 1000)

// -----------------------------------------------------------------
// Command and recovery lengths in ISA clocks, before any wait states
// -----------------------------------------------------------------
`define IOCR_CMD8_TICKS 4
`define IOCR_CMD16_TICKS 1
`define IOCR_RECOVERY_TICKS 1

// -----------------------------------------------------------------
// Widths and reset values
// -----------------------------------------------------------------
`define IOCR_LA_WIDTH 7
`define IOCR_LA_RESET 7'h00
`define IOCR_CNT_WIDTH 4

`endif

//--- rtl/iocr_pkg.sv
// Types for the ISA I/O command and channel-ready logic
package iocr_pkg;

  // -----------------------------------------------------------------
  // Master cycle sequencer states
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    IOCR_M_IDLE,
    IOCR_M_SETUP,
    IOCR_M_CMD,
    IOCR_M_WAIT,
    IOCR_M_RECOVER
  } iocr_mstate_e;

  // -----------------------------------------------------------------
  // Target channel-ready driver states
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {
    IOCR_T_IDLE,
    IOCR_T_HOLD_LOW,
    IOCR_T_DRIVE_HIGH,
    IOCR_T_WAIT_END
  } iocr_tstate_e;

endpackage

//--- rtl/iocr_isa_tick.sv
// ISA clock tick generator derived from the system clock
`timescale 1ns/10ps
`include "iocr_consts.svh"
module iocr_isa_tick #(
  parameter int DIV = `IOCR_ISA_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);

  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;

  initial begin
    if (DIV < 2 || DIV > 255) begin
      $error("iocr_isa_tick: DIV out of range");
    end
  end

  always_comb begin
    if (cnt_ff == 8'(DIV - 1)) begin
      nxt_cnt = 8'h00;
    end else begin
      nxt_cnt = cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign tick = (cnt_ff == 8'(DIV - 1));

endmodule

//--- rtl/iocr_isa_io_ctrl.sv
// ISA I/O read/write commands, channel ready, 16-bit select and upper address
`timescale 1ns/10ps
`include "iocr_consts.svh"
// Function
// - Slave pulls ready low for more time; master waits until it returns high.
// - Ready is an input during own CPU, PCI or DMA cycles.
// - Ready driven only when external master targets DRAM or our registers.
// - As target, drive ready low from the command falling edge.
// - After data ready, drive ready high then float; 70 ns total.
// - Ready left floating when external master accesses another slave.
// - Ready floats during reset, after reset and in power-on suspend.
// - Slave asserts 16-bit select; device then runs a 16-bit I/O cycle.
// - Read command driven when owning the bus, sensed otherwise.
// - Write command tells slave to capture data; driven or sensed by ownership.
// - Commands float in reset, are driven high after reset and in suspend.
// - Seven upper address lines driven while the device owns the bus.
// - Upper address lines are inputs sampled when an external master owns.
// - In extended I/O mode the upper address lines are general outputs; own cycles still drive req_la on them.
module iocr_isa_io_ctrl
  import iocr_pkg::*;
#(
  parameter int ISA_DIV = `IOCR_ISA_DIV,
  parameter int CMD8_TICKS = `IOCR_CMD8_TICKS,
  parameter int CMD16_TICKS = `IOCR_CMD16_TICKS,
  parameter int RDY_RELEASE_CYC = `IOCR_RDY_RELEASE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pos_active,
  input wire logic extended_io_bus_option,
  input wire logic [6:0] general_outputs_alt,
  input wire logic ext_master_owns,
  input wire logic ext_target_hit,
  input wire logic target_data_done,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_dma,
  input wire logic [6:0] req_la,
  output logic req_ready,
  output logic cyc_done,
  output logic cyc_is16,
  output logic cyc_waits_seen,
  output logic ext_cmd_start,
  output logic ext_cmd_write,
  output logic [6:0] ext_la,
  input wire logic iochrdy_i,
  output logic iochrdy_o,
  output logic iochrdy_oe,
  input wire logic iocs16_n_i,
  input wire logic ior_n_i,
  output logic ior_n_o,
  output logic ior_n_oe,
  input wire logic iow_n_i,
  output logic iow_n_o,
  output logic iow_n_oe,
  input wire logic [6:0] la_i,
  output logic [6:0] la_o,
  output logic la_oe
);

  initial begin
    if (CMD8_TICKS < 1 || CMD8_TICKS > 15 || CMD16_TICKS < 1 || CMD16_TICKS > 15) begin
      $error("iocr_isa_io_ctrl: command length out of range");
    end
    if (RDY_RELEASE_CYC < 2 || RDY_RELEASE_CYC > 15) begin
      $error("iocr_isa_io_ctrl: ready release count out of range");
    end
  end

  // -----------------------------------------------------------------
  // ISA clock
  // -----------------------------------------------------------------
  logic isa_tick;

  iocr_isa_tick #(
    .DIV(ISA_DIV)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(isa_tick)
  );

  // -----------------------------------------------------------------
  // Pin direction state
  // -----------------------------------------------------------------
  logic out_ready_ff;
  logic nxt_out_ready;
  logic own_bus;

  // Commands stay floating until the first edge after reset release
  always_comb begin
    nxt_out_ready = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_ready_ff <= 1'b0;
    end else begin
      out_ready_ff <= nxt_out_ready;
    end
  end

  assign own_bus = out_ready_ff && !ext_master_owns;

  // -----------------------------------------------------------------
  // Master cycle sequencer
  // -----------------------------------------------------------------
  iocr_mstate_e mst_ff;
  iocr_mstate_e nxt_mst;
  logic [`IOCR_CNT_WIDTH-1:0] cnt_ff;
  logic [`IOCR_CNT_WIDTH-1:0] nxt_cnt;
  logic write_ff;
  logic nxt_write;
  logic is16_ff;
  logic nxt_is16;
  logic waited_ff;
  logic nxt_waited;
  logic done_ff;
  logic nxt_done;
  logic ior_ff;
  logic nxt_ior;
  logic iow_ff;
  logic nxt_iow;
  logic [6:0] la_ff;
  logic [6:0] nxt_la;
  logic can_start;

  function automatic logic [`IOCR_CNT_WIDTH-1:0] cmd_len(input logic wide);
    if (wide) begin
      cmd_len = `IOCR_CNT_WIDTH'(CMD16_TICKS);
    end else begin
      cmd_len = `IOCR_CNT_WIDTH'(CMD8_TICKS);
    end
  endfunction

  assign can_start = own_bus && !pos_active && (mst_ff == IOCR_M_IDLE);

  always_comb begin
    nxt_mst = mst_ff;
    nxt_cnt = cnt_ff;
    nxt_write = write_ff;
    nxt_is16 = is16_ff;
    nxt_waited = waited_ff;
    nxt_done = 1'b0;
    nxt_ior = 1'b1;
    nxt_iow = 1'b1;
    nxt_la = la_ff;
    case (mst_ff)
      IOCR_M_IDLE: begin
        if (extended_io_bus_option) begin
          nxt_la = general_outputs_alt;
        end
        if (can_start && req_valid) begin
          nxt_la = req_la;
          nxt_write = req_write;
          nxt_waited = 1'b0;
          nxt_mst = IOCR_M_SETUP;
        end
      end
      IOCR_M_SETUP: begin
        // Address is driven on entry; the command falls on the next ISA tick, 1 to ISA_DIV clocks later
        if (isa_tick) begin
          nxt_ior = write_ff;
          nxt_iow = !write_ff;
          nxt_is16 = !iocs16_n_i;
          nxt_cnt = cmd_len(!iocs16_n_i);
          nxt_mst = IOCR_M_CMD;
        end
      end
      IOCR_M_CMD: begin
        nxt_ior = ior_ff;
        nxt_iow = iow_ff;
        if (isa_tick) begin
          if (cnt_ff > `IOCR_CNT_WIDTH'(1)) begin
            nxt_cnt = cnt_ff - `IOCR_CNT_WIDTH'(1);
          end else if (!iochrdy_i) begin
            nxt_waited = 1'b1;
            nxt_mst = IOCR_M_WAIT;
          end else begin
            nxt_ior = 1'b1;
            nxt_iow = 1'b1;
            nxt_done = 1'b1;
            nxt_cnt = `IOCR_CNT_WIDTH'(`IOCR_RECOVERY_TICKS);
            nxt_mst = IOCR_M_RECOVER;
          end
        end
      end
      IOCR_M_WAIT: begin
        // One wait state per ISA clock on which ready is sampled low
        nxt_ior = ior_ff;
        nxt_iow = iow_ff;
        if (isa_tick && iochrdy_i) begin
          nxt_ior = 1'b1;
          nxt_iow = 1'b1;
          nxt_done = 1'b1;
          nxt_cnt = `IOCR_CNT_WIDTH'(`IOCR_RECOVERY_TICKS);
          nxt_mst = IOCR_M_RECOVER;
        end
      end
      IOCR_M_RECOVER: begin
        if (isa_tick) begin
          if (cnt_ff > `IOCR_CNT_WIDTH'(1)) begin
            nxt_cnt = cnt_ff - `IOCR_CNT_WIDTH'(1);
          end else begin
            nxt_mst = IOCR_M_IDLE;
          end
        end
      end
      default: begin
        nxt_mst = IOCR_M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mst_ff <= IOCR_M_IDLE;
      cnt_ff <= '0;
      write_ff <= 1'b0;
      is16_ff <= 1'b0;
      waited_ff <= 1'b0;
      done_ff <= 1'b0;
      ior_ff <= 1'b1;
      iow_ff <= 1'b1;
      la_ff <= `IOCR_LA_RESET;
    end else begin
      mst_ff <= nxt_mst;
      cnt_ff <= nxt_cnt;
      write_ff <= nxt_write;
      is16_ff <= nxt_is16;
      waited_ff <= nxt_waited;
      done_ff <= nxt_done;
      ior_ff <= nxt_ior;
      iow_ff <= nxt_iow;
      la_ff <= nxt_la;
    end
  end

  // Request handshake; the DMA flag only marks that ready is sensed too
  assign req_ready = can_start && (req_dma || !req_dma);
  assign cyc_done = done_ff;
  assign cyc_is16 = is16_ff;
  assign cyc_waits_seen = waited_ff;

  // -----------------------------------------------------------------
  // Command and address pin drivers
  // -----------------------------------------------------------------
  assign ior_n_o = ior_ff;
  assign iow_n_o = iow_ff;
  assign ior_n_oe = own_bus;
  assign iow_n_oe = own_bus;
  assign la_o = la_ff;
  // Suspend keeps the last address driven; extended mode drives always
  assign la_oe = out_ready_ff && (extended_io_bus_option || !ext_master_owns);

  // -----------------------------------------------------------------
  // External master command sensing
  // -----------------------------------------------------------------
  logic ior_prev_ff;
  logic nxt_ior_prev;
  logic iow_prev_ff;
  logic nxt_iow_prev;
  logic start_ff;
  logic nxt_start;
  logic ext_wr_ff;
  logic nxt_ext_wr;
  logic [6:0] ext_la_ff;
  logic [6:0] nxt_ext_la;
  logic cmd_fall;
  logic cmd_low;

  assign cmd_fall = ext_master_owns &&
                    ((ior_prev_ff && !ior_n_i) || (iow_prev_ff && !iow_n_i));
  assign cmd_low = !ior_n_i || !iow_n_i;

  always_comb begin
    nxt_ior_prev = ior_n_i;
    nxt_iow_prev = iow_n_i;
    nxt_start = 1'b0;
    nxt_ext_wr = ext_wr_ff;
    nxt_ext_la = ext_la_ff;
    if (cmd_fall && !extended_io_bus_option) begin
      nxt_start = 1'b1;
      nxt_ext_wr = !iow_n_i;
      nxt_ext_la = la_i;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ior_prev_ff <= 1'b1;
      iow_prev_ff <= 1'b1;
      start_ff <= 1'b0;
      ext_wr_ff <= 1'b0;
      ext_la_ff <= `IOCR_LA_RESET;
    end else begin
      ior_prev_ff <= nxt_ior_prev;
      iow_prev_ff <= nxt_iow_prev;
      start_ff <= nxt_start;
      ext_wr_ff <= nxt_ext_wr;
      ext_la_ff <= nxt_ext_la;
    end
  end

  assign ext_cmd_start = start_ff;
  assign ext_cmd_write = ext_wr_ff;
  assign ext_la = ext_la_ff;

  // -----------------------------------------------------------------
  // Target channel-ready driver
  // -----------------------------------------------------------------
  iocr_tstate_e tst_ff;
  iocr_tstate_e nxt_tst;
  logic [`IOCR_CNT_WIDTH-1:0] rcnt_ff;
  logic [`IOCR_CNT_WIDTH-1:0] nxt_rcnt;
  logic rdy_o_ff;
  logic nxt_rdy_o;
  logic rdy_oe_ff;
  logic nxt_rdy_oe;

  always_comb begin
    nxt_tst = tst_ff;
    nxt_rcnt = rcnt_ff;
    nxt_rdy_o = 1'b1;
    nxt_rdy_oe = 1'b0;
    case (tst_ff)
      IOCR_T_IDLE: begin
        // Other slaves pace their own cycles
        if (cmd_fall && ext_target_hit && !pos_active) begin
          nxt_rdy_o = 1'b0;
          nxt_rdy_oe = 1'b1;
          nxt_tst = IOCR_T_HOLD_LOW;
        end
      end
      IOCR_T_HOLD_LOW: begin
        nxt_rdy_o = 1'b0;
        nxt_rdy_oe = 1'b1;
        if (target_data_done) begin
          nxt_rdy_o = 1'b1;
          // This cycle is the first high one; the last cycle of the window floats
          nxt_rcnt = `IOCR_CNT_WIDTH'(RDY_RELEASE_CYC - 1);
          nxt_tst = IOCR_T_DRIVE_HIGH;
        end else if (!cmd_low || !ext_master_owns) begin
          nxt_rdy_oe = 1'b0;
          nxt_tst = IOCR_T_IDLE;
        end
      end
      IOCR_T_DRIVE_HIGH: begin
        // Drive plus release must fit in the window, so float on the last cycle
        if (rcnt_ff > `IOCR_CNT_WIDTH'(1)) begin
          nxt_rdy_oe = 1'b1;
          nxt_rcnt = rcnt_ff - `IOCR_CNT_WIDTH'(1);
        end else begin
          nxt_tst = IOCR_T_WAIT_END;
        end
      end
      IOCR_T_WAIT_END: begin
        if (!cmd_low) begin
          nxt_tst = IOCR_T_IDLE;
        end
      end
      default: begin
        nxt_tst = IOCR_T_IDLE;
      end
    endcase
    if (pos_active) begin
      nxt_rdy_oe = 1'b0;
      nxt_tst = IOCR_T_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tst_ff <= IOCR_T_IDLE;
      rcnt_ff <= '0;
      rdy_o_ff <= 1'b1;
      rdy_oe_ff <= 1'b0;
    end else begin
      tst_ff <= nxt_tst;
      rcnt_ff <= nxt_rcnt;
      rdy_o_ff <= nxt_rdy_o;
      rdy_oe_ff <= nxt_rdy_oe;
    end
  end

  assign iochrdy_o = rdy_o_ff;
  assign iochrdy_oe = rdy_oe_ff;

endmodule

//--- bench/iocr_isa_io_ctrl_sva.sv
// Checker for the ISA I/O command and channel-ready logic
`timescale 1ns/10ps
module iocr_isa_io_ctrl_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pos_active,
  input wire logic ext_master_owns,
  input wire logic ext_target_hit,
  input wire logic target_data_done,
  input wire logic iochrdy_i,
  input wire logic iochrdy_o,
  input wire logic iochrdy_oe,
  input wire logic ior_n_i,
  input wire logic ior_n_o,
  input wire logic ior_n_oe,
  input wire logic iow_n_i,
  input wire logic iow_n_o,
  input wire logic iow_n_oe,
  input wire logic la_oe
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  wire logic cmd_low = !ior_n_o || !iow_n_o;
  wire logic ext_fall_hit = ext_master_owns && ext_target_hit && !pos_active;
  sequence rdy_high_run;
    (iochrdy_oe && iochrdy_o) [*6];
  endsequence
  rst_float_a: assert property ($rose(rst_n) |-> !iochrdy_oe && !ior_n_oe && !iow_n_oe)
    else $error("pins driven at reset release");
  cmd_dir_a: assert property (ext_master_owns |-> !ior_n_oe && !iow_n_oe)
    else $error("command driven under external master");
  cmd_own_a: assert property ($past(rst_n) && !ext_master_owns |-> ior_n_oe && iow_n_oe)
    else $error("command not driven while owning bus");
  la_in_a: assert property (ext_master_owns && $past(ext_master_owns) |-> !la_oe)
    else $error("address driven under external master");
  la_out_a: assert property ($past(rst_n) && !ext_master_owns && !$past(ext_master_owns)
    |-> la_oe)
    else $error("address not driven while owning bus");
  cmd_pos_a: assert property (pos_active |-> ior_n_o && iow_n_o)
    else $error("command low in suspend");
  rdy_pos_a: assert property (pos_active && $past(pos_active) |-> !iochrdy_oe)
    else $error("ready driven in suspend");
  rdy_low_a: assert property (ext_fall_hit && ($fell(ior_n_i) || $fell(iow_n_i))
    |=> iochrdy_oe && !iochrdy_o)
    else $error("ready not pulled low on command fall");
  rdy_miss_a: assert property (ext_master_owns && !ext_target_hit
    && ($fell(ior_n_i) || $fell(iow_n_i)) |=> !iochrdy_oe)
    else $error("ready driven for foreign slave");
  rdy_release_a: assert property (iochrdy_oe && !iochrdy_o && target_data_done
    |=> rdy_high_run ##1 !iochrdy_oe)
    else $error("ready release window wrong");
  cmd_wait_a: assert property (cmd_low && !iochrdy_i |=> cmd_low)
    else $error("command ended while ready low");
endmodule

//--- bench/iocr_isa_slave.sv
// Behavioural ISA I/O slave: 16-bit select and ready stretching
`timescale 1ns/10ps
module iocr_isa_slave (
  input wire logic clk,
  input wire logic ior_n,
  input wire logic iow_n,
  input wire logic sixteen,
  input wire logic [7:0] waits,
  input wire logic [6:0] la,
  output logic iocs16_n,
  output logic rdy_pull,
  output logic rd_valid,
  output logic [6:0] la_seen
);
  // ----------------------------------------
  // Responder
  // ----------------------------------------
  logic cmd_q = 1'h0;
  logic [7:0] cnt = 8'h00;
  logic rd_hold = 1'h0;
  // Read data stays valid one clock past the read command
  assign rd_valid = !ior_n || rd_hold;
  // Open-drain select: released means the pull-up reads high
  assign iocs16_n = !sixteen;
  assign rdy_pull = cnt != 8'h00;
  always @(posedge clk) begin
    cmd_q <= !(ior_n && iow_n);
    if (!(ior_n && iow_n) && !cmd_q)
      cnt <= waits;
    else if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
    rd_hold <= !ior_n;
    // No latch strobe here; the command fall stands in for its trailing edge
    if (!(ior_n && iow_n) && !cmd_q)
      la_seen <= la;
  end
endmodule

//--- bench/iocr_isa_io_ctrl_tb.sv
// Testbench for the ISA I/O command and channel-ready logic
`timescale 1ns/10ps
module iocr_isa_io_ctrl_tb;
  import iocr_pkg::*;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic pos_active = 1'h0;
  logic extended_io_bus_option = 1'h0;
  logic [6:0] general_outputs_alt = 7'h00;
  logic ext_master_owns = 1'h0;
  logic ext_target_hit = 1'h0;
  logic target_data_done = 1'h0;
  logic req_valid = 1'h0;
  logic req_write = 1'h0;
  logic req_dma = 1'h0;
  logic [6:0] req_la = 7'h00;
  logic m_ior = 1'h1;
  logic m_iow = 1'h1;
  logic [6:0] m_la = 7'h00;
  logic sixteen = 1'h0;
  logic [7:0] waits = 8'h00;
  logic req_ready, cyc_done, cyc_is16, cyc_waits_seen, ext_cmd_start, ext_cmd_write;
  logic iochrdy_o, iochrdy_oe, ior_n_o, ior_n_oe, iow_n_o, iow_n_oe, la_oe, iocs16_n, rdy_pull;
  logic [6:0] ext_la, la_o, la_seen;
  logic rd_valid;
  int fails = 0;
  int cmp_count = 0;
  // Pin levels resolved from every party's enable; ready has a pull-up
  wire logic rdy_w = iochrdy_oe ? iochrdy_o : !rdy_pull;
  wire logic ior_w = ior_n_oe ? ior_n_o : m_ior;
  wire logic iow_w = iow_n_oe ? iow_n_o : m_iow;
  wire logic [6:0] la_w = la_oe ? la_o : m_la;

  iocr_isa_io_ctrl dut (.clk, .rst_n, .pos_active, .extended_io_bus_option,
    .general_outputs_alt, .ext_master_owns, .ext_target_hit, .target_data_done,
    .req_valid, .req_write, .req_dma, .req_la, .req_ready, .cyc_done, .cyc_is16,
    .cyc_waits_seen, .ext_cmd_start, .ext_cmd_write, .ext_la, .iochrdy_i(rdy_w),
    .iochrdy_o, .iochrdy_oe, .iocs16_n_i(iocs16_n), .ior_n_i(ior_w), .ior_n_o,
    .ior_n_oe, .iow_n_i(iow_w), .iow_n_o, .iow_n_oe, .la_i(la_w), .la_o, .la_oe);
  iocr_isa_slave slave (.clk, .ior_n(ior_w), .iow_n(iow_w), .sixteen, .waits,
    .la(la_w), .iocs16_n, .rdy_pull, .rd_valid, .la_seen);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic bit ck(input logic ok);
    cmp_count++;
    return ok === 1'h1;
  endfunction
  task bad(input string m);
    fails++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task end_sim;
    if (fails == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  initial begin
    #200000;
    bad("watchdog expired");
    end_sim;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    repeat (20) @(negedge clk);
    if (!ck(!iochrdy_oe && !ior_n_oe && !iow_n_oe && !la_oe)) bad("driven in reset");
    @(posedge clk);
    rst_n <= 1'h1;
    repeat (3) @(negedge clk);
    if (!ck(ior_w && iow_w && !iochrdy_oe && ior_n_oe)) bad("idle pins after reset");
  endtask
  task t_master(input logic w, input logic s16, input logic [7:0] wt, input logic [6:0] a);
    int n;
    int base;
    base = s16 ? 4 : 16;
    @(posedge clk);
    sixteen <= s16;
    waits <= wt;
    req_valid <= 1'h1;
    req_write <= w;
    req_dma <= w;
    req_la <= a;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if (req_ready === 1'h1)
        break;
    end
    req_valid <= 1'h0;
    for (n = 0; n < 50 && (w ? iow_w : ior_w) !== 1'h0; n++) @(negedge clk);
    if (!ck(la_w === a && (w ? ior_w : iow_w))) bad("address or command line");
    for (n = 0; n < 400 && (w ? iow_w : ior_w) === 1'h0; n++) @(negedge clk);
    if (!ck(la_seen === a && (w || rd_valid))) bad("slave view of cycle");
    if (wt == 8'h00) begin
      if (!ck(n == base)) bad("command length");
    end else begin
      if (!ck(n >= wt && n % 4 == 0 && n <= base + wt + 8)) bad("wait states");
    end
    for (n = 0; n < 8 && cyc_done !== 1'h1; n++) @(negedge clk);
    if (!ck(cyc_done && cyc_is16 === s16 && cyc_waits_seen === (wt != 8'h00)))
      bad("cycle status");
  endtask
  task t_target(input logic w, input logic h);
    int n;
    @(posedge clk);
    waits <= 8'h00;
    ext_target_hit <= h;
    ext_master_owns <= 1'h1;
    m_la <= 7'h2b;
    repeat (2) @(posedge clk);
    if (w)
      m_iow <= 1'h0;
    else
      m_ior <= 1'h0;
    repeat (2) @(negedge clk);
    if (!ck(ext_cmd_start && ext_cmd_write === w && ext_la === 7'h2b)) bad("ext command");
    if (!ck(rdy_w === !h && iochrdy_oe === h)) bad("ready on command fall");
    repeat (4) @(posedge clk);
    target_data_done <= 1'h1;
    @(posedge clk);
    target_data_done <= 1'h0;
    for (n = 0; n < 20 && !(iochrdy_oe && iochrdy_o); n++) @(negedge clk);
    for (n = 0; n < 20 && iochrdy_oe && iochrdy_o; n++) @(negedge clk);
    if (!ck(n == (h ? 6 : 0) && rdy_w)) bad("ready release");
    @(posedge clk);
    m_iow <= 1'h1;
    m_ior <= 1'h1;
    @(posedge clk);
    ext_master_owns <= 1'h0;
  endtask
  task t_suspend;
    @(posedge clk);
    pos_active <= 1'h1;
    ext_target_hit <= 1'h1;
    ext_master_owns <= 1'h1;
    repeat (2) @(posedge clk);
    m_ior <= 1'h0;
    repeat (3) @(negedge clk);
    if (!ck(!iochrdy_oe && rdy_w)) bad("ready driven in suspend");
    @(posedge clk);
    m_ior <= 1'h1;
    ext_master_owns <= 1'h0;
    repeat (2) @(negedge clk);
    if (!ck(!req_ready && ior_w && iow_w && ior_n_oe)) bad("suspend commands");
    @(posedge clk);
    pos_active <= 1'h0;
  endtask
  task t_eio;
    @(posedge clk);
    extended_io_bus_option <= 1'h1;
    general_outputs_alt <= 7'h5a;
    repeat (4) @(negedge clk);
    if (!ck(la_w === 7'h5a)) bad("general outputs");
    @(posedge clk);
    extended_io_bus_option <= 1'h0;
  endtask

  initial begin
    t_reset;
    t_master(1'h0, 1'h0, 8'h00, 7'h35);
    t_master(1'h1, 1'h1, 8'h00, 7'h4a);
    t_master(1'h0, 1'h1, 8'h0c, 7'h01);
    t_master(1'h1, 1'h0, 8'h19, 7'h7e);
    t_target(1'h1, 1'h1);
    t_target(1'h0, 1'h1);
    t_target(1'h1, 1'h0);
    t_suspend;
    t_eio;
    end_sim;
  end
endmodule

bind iocr_isa_io_ctrl iocr_isa_io_ctrl_sva chk (.clk, .rst_n, .pos_active, .ext_master_owns,
  .ext_target_hit, .target_data_done, .iochrdy_i, .iochrdy_o, .iochrdy_oe, .ior_n_i,
  .ior_n_o, .ior_n_oe, .iow_n_i, .iow_n_o, .iow_n_oe, .la_oe);
